/* core/ecfl_loader.sv */
// configuration flag loader with its control and status registers on wishbone
`timescale 1ns/1ps
`include "ecfl_consts.svh"

module ecfl_loader
  import ecfl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output ecfl_memreq_t memReq,
  input wire logic memAck,
  input wire logic [7:0] memData,
  output ecfl_cfg_t cfg,
  output logic loadDone,
  output logic descFromRam,
  output logic [15:0] vendorId,
  output logic [15:0] productId
);

  ecfl_state_t state;
  logic [7:0] img [0:37];
  logic [5:0] imgIdx;
  logic [9:0] imgBase;
  logic memValid;
  logic eeValid;
  logic otpValid;
  logic ackGap;
  logic reqAddrSrc;
  logic [9:0] reqAddr;
  logic [31:0] regs [0:13];
  logic attrWritten;
  logic descWritten;
  logic orderOk;
  logic busHit;
  logic busWr;
  logic [3:0] busIdx;
  logic [31:0] byteMask;
  logic [31:0] next_emuWord;
  logic emuRise;
  logic [31:0] flags0;
  logic [31:0] flags1;
  logic [31:0] flags2;
  logic [31:0] flags3;
  logic [63:0] gpioWord;

  function automatic logic [31:0] imgWord(input logic [5:0] pos);
    imgWord = {img[pos + 6'd3], img[pos + 6'd2], img[pos + 6'd1], img[pos]};
  endfunction

  function automatic logic [31:0] regMask(input logic [3:0] idx);
    unique case (idx)
      `ECFL_IDX_HWCFG: regMask = `ECFL_MASK_HWCFG;
      `ECFL_IDX_PMT: regMask = `ECFL_MASK_PMT;
      `ECFL_IDX_PIPE: regMask = `ECFL_MASK_PIPE;
      `ECFL_IDX_MACCR: regMask = `ECFL_MASK_MACCR;
      `ECFL_IDX_USB0: regMask = `ECFL_MASK_USB0;
      `ECFL_IDX_USB1: regMask = `ECFL_MASK_USB1;
      `ECFL_IDX_USB2: regMask = `ECFL_MASK_USB2;
      `ECFL_IDX_PIN0: regMask = `ECFL_MASK_PIN;
      `ECFL_IDX_PIN1: regMask = `ECFL_MASK_PIN;
      `ECFL_IDX_WAKE: regMask = `ECFL_MASK_PIN;
      `ECFL_IDX_MACL: regMask = `ECFL_MASK_MACL;
      `ECFL_IDX_MACH: regMask = `ECFL_MASK_MACH;
      `ECFL_IDX_ATTR: regMask = `ECFL_MASK_ATTR;
      `ECFL_IDX_DESC: regMask = `ECFL_MASK_DESC;
      default: regMask = 32'h00000000;
    endcase
  endfunction

  // a process rather than assigns: the function reads img, which an assign would not watch
  always_comb begin
    flags0 = imgWord(`ECFL_IMG_FLAGS0);
    flags1 = imgWord(`ECFL_IMG_FLAGS1);
    flags2 = imgWord(`ECFL_IMG_FLAGS2);
    flags3 = imgWord(`ECFL_IMG_FLAGS3);
    gpioWord = {imgWord(`ECFL_IMG_GPIO + 6'd4), imgWord(`ECFL_IMG_GPIO)};
  end

  // memory read port: one byte per ack, request dropped for a cycle after each ack
  assign memReq.req = (state == ECFL_EE_SIG || state == ECFL_OTP_SIG || state == ECFL_FETCH)
                      && !ackGap;
  assign memReq.src = reqAddrSrc;
  assign memReq.addr = reqAddr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ackGap <= 1'b0;
    end else begin
      ackGap <= memAck;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ECFL_EE_SIG;
      imgIdx <= 6'd0;
      imgBase <= `ECFL_EE_BASE;
      reqAddr <= `ECFL_SIG_ADDR;
      reqAddrSrc <= 1'b0;
      memValid <= 1'b0;
      eeValid <= 1'b0;
      otpValid <= 1'b0;
    end else begin
      unique case (state)
        ECFL_EE_SIG: begin
          if (memAck) begin
            if (memData == `ECFL_EE_SIG) begin
              eeValid <= 1'b1;
              memValid <= 1'b1;
              imgBase <= `ECFL_EE_BASE;
              reqAddr <= `ECFL_EE_BASE;
              state <= ECFL_FETCH;
            end else begin
              reqAddrSrc <= 1'b1;
              reqAddr <= `ECFL_SIG_ADDR;
              state <= ECFL_OTP_SIG;
            end
          end
        end
        ECFL_OTP_SIG: begin
          if (memAck) begin
            if (memData == `ECFL_OTP_SIG_LOW) begin
              otpValid <= 1'b1;
              memValid <= 1'b1;
              imgBase <= `ECFL_OTP_BASE_LOW;
              reqAddr <= `ECFL_OTP_BASE_LOW;
              state <= ECFL_FETCH;
            end else if (memData == `ECFL_OTP_SIG_HIGH) begin
              otpValid <= 1'b1;
              memValid <= 1'b1;
              imgBase <= `ECFL_OTP_BASE_HIGH;
              reqAddr <= `ECFL_OTP_BASE_HIGH;
              state <= ECFL_FETCH;
            end else begin
              state <= ECFL_APPLY;
            end
          end
        end
        ECFL_FETCH: begin
          if (memAck) begin
            if (imgIdx == `ECFL_IMG_LAST) begin
              state <= ECFL_APPLY;
            end else begin
              imgIdx <= imgIdx + 6'd1;
              reqAddr <= imgBase + {4'h0, imgIdx + 6'd1};
            end
          end
        end
        ECFL_APPLY: begin
          state <= ECFL_DONE;
        end
        ECFL_DONE: begin
          state <= ECFL_DONE;
        end
      endcase
    end
  end

  // image bytes carry no reset: they are read only once memValid has been set
  always_ff @(posedge clk) begin
    if (state == ECFL_FETCH && memAck) begin
      img[imgIdx] <= memData;
    end
  end

  assign loadDone = (state == ECFL_DONE);

  // wishbone classic slave, one wait state, unmapped words read zero and ignore writes
  // writes land on the edge at which the master samples ack, while it still holds the request
  assign busIdx = wb_adr_i[5:2];
  assign busHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (busIdx <= `ECFL_IDX_LAST);
  assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busHit;
      if (busHit && !wb_we_i) begin
        if (busIdx == `ECFL_IDX_HWCFG) begin
          wb_dat_o <= regs[busIdx] | ({31'h0, loadDone} << `ECFL_HW_DONE)
                      | ({31'h0, eeValid} << `ECFL_HW_EE_OK)
                      | ({31'h0, otpValid} << `ECFL_HW_OTP_OK);
        end else if (busIdx <= `ECFL_IDX_LAST) begin
          wb_dat_o <= regs[busIdx];
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  // attribute writes must precede the first descriptor ram write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      attrWritten <= 1'b0;
      descWritten <= 1'b0;
      orderOk <= 1'b0;
    end else begin
      if (busWr && busIdx == `ECFL_IDX_ATTR) begin
        attrWritten <= 1'b1;
      end
      if (busWr && busIdx == `ECFL_IDX_DESC && !descWritten) begin
        descWritten <= 1'b1;
        orderOk <= attrWritten;
      end
    end
  end

  assign next_emuWord = (regs[`ECFL_IDX_HWCFG] & ~(byteMask & `ECFL_MASK_HWCFG))
                        | (wb_dat_i & byteMask & `ECFL_MASK_HWCFG);
  assign emuRise = busWr && busIdx == `ECFL_IDX_HWCFG && next_emuWord[`ECFL_HW_EMU]
                   && !regs[`ECFL_IDX_HWCFG][`ECFL_HW_EMU];

  // hardware load has priority over a bus write landing in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i <= 13; i++) begin
        regs[i] <= `ECFL_DEF_REG;
      end
    end else if (state == ECFL_APPLY && memValid) begin
      regs[`ECFL_IDX_PMT] <= flags1 & `ECFL_MASK_PMT;
      regs[`ECFL_IDX_PIPE] <= flags1 & `ECFL_MASK_PIPE;
      regs[`ECFL_IDX_MACCR] <= (flags2 & `ECFL_MASK_MACCR & ~32'h3)
                               | ({31'h0, flags0[`ECFL_F0_ASD]} << `ECFL_MAC_ASD)
                               | ({31'h0, flags0[`ECFL_F0_ADD]} << `ECFL_MAC_ADD);
      regs[`ECFL_IDX_HWCFG] <= (regs[`ECFL_IDX_HWCFG] & 32'hffffffe1)
                               | ({31'h0, flags2[`ECFL_F2_SPEEDUP]} << `ECFL_HW_SPEEDUP)
                               | ({31'h0, flags0[`ECFL_F0_SUSP_POL]} << `ECFL_HW_SUSP_POL)
                               | ({30'h0, flags0[`ECFL_F0_SUSP_SEL +: 2]} << `ECFL_HW_SUSP_SEL);
      regs[`ECFL_IDX_USB0] <= (regs[`ECFL_IDX_USB0] & 32'hffffff80) | (flags0 & 32'h0000007f);
      regs[`ECFL_IDX_USB1] <= flags2 & `ECFL_MASK_USB1;
      regs[`ECFL_IDX_USB2] <= flags3 & `ECFL_MASK_USB2;
      regs[`ECFL_IDX_PIN0] <= {4'h0, gpioWord[27:16], 4'h0, gpioWord[11:0]};
      regs[`ECFL_IDX_PIN1] <= {4'h0, gpioWord[59:48], 4'h0, gpioWord[43:32]};
      regs[`ECFL_IDX_WAKE] <= imgWord(`ECFL_IMG_WAKE) & `ECFL_MASK_PIN;
      regs[`ECFL_IDX_MACL] <= imgWord(`ECFL_IMG_MAC);
      regs[`ECFL_IDX_MACH] <= {16'h0000, img[`ECFL_IMG_MAC + 6'd5], img[`ECFL_IMG_MAC + 6'd4]};
    end else if (busWr) begin
      regs[busIdx] <= (regs[busIdx] & ~(byteMask & regMask(busIdx)))
                      | (wb_dat_i & byteMask & regMask(busIdx));
      if (emuRise && orderOk) begin
        regs[`ECFL_IDX_USB0][`ECFL_USB0_PWR] <= regs[`ECFL_IDX_DESC][`ECFL_DESC_PWR];
        regs[`ECFL_IDX_USB0][`ECFL_USB0_RMT] <= regs[`ECFL_IDX_DESC][`ECFL_DESC_RMT];
      end
    end
  end

  assign descFromRam = regs[`ECFL_IDX_HWCFG][`ECFL_HW_EMU];

  // identity values are taken from memory only when it was found valid
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vendorId <= `ECFL_DEF_VID;
      productId <= `ECFL_DEF_PID;
    end else if (state == ECFL_APPLY && memValid) begin
      vendorId <= {img[`ECFL_IMG_VID + 6'd1], img[`ECFL_IMG_VID]};
      productId <= {img[`ECFL_IMG_PID + 6'd1], img[`ECFL_IMG_PID]};
    end
  end

  assign cfg.hwCfg = regs[`ECFL_IDX_HWCFG];
  assign cfg.pmtCtl = regs[`ECFL_IDX_PMT];
  assign cfg.pipeCtl = regs[`ECFL_IDX_PIPE];
  assign cfg.macCr = regs[`ECFL_IDX_MACCR];
  assign cfg.usbCfg0 = regs[`ECFL_IDX_USB0];
  assign cfg.usbCfg1 = regs[`ECFL_IDX_USB1];
  assign cfg.usbCfg2 = regs[`ECFL_IDX_USB2];
  assign cfg.pinCfg0 = regs[`ECFL_IDX_PIN0];
  assign cfg.pinCfg1 = regs[`ECFL_IDX_PIN1];
  assign cfg.pinWake = regs[`ECFL_IDX_WAKE];
  assign cfg.macAddrLow = regs[`ECFL_IDX_MACL];
  assign cfg.macAddrHigh = regs[`ECFL_IDX_MACH];

endmodule

/* core/ecfl_consts.svh */
// constants of the configuration flag loader: offsets, fields, defaults, signatures
`ifndef ECFL_CONSTS_SVH
`define ECFL_CONSTS_SVH

// memory signatures and image placement
`define ECFL_EE_SIG 8'ha5
`define ECFL_OTP_SIG_LOW 8'hf3
`define ECFL_OTP_SIG_HIGH 8'hf7
`define ECFL_SIG_ADDR 10'h000
`define ECFL_EE_BASE 10'h001
`define ECFL_OTP_BASE_LOW 10'h001
`define ECFL_OTP_BASE_HIGH 10'h101

// byte positions inside the loaded image
`define ECFL_IMG_MAC 6'd0
`define ECFL_IMG_FLAGS0 6'd6
`define ECFL_IMG_FLAGS1 6'd10
`define ECFL_IMG_FLAGS2 6'd14
`define ECFL_IMG_FLAGS3 6'd18
`define ECFL_IMG_GPIO 6'd22
`define ECFL_IMG_WAKE 6'd30
`define ECFL_IMG_VID 6'd34
`define ECFL_IMG_PID 6'd36
`define ECFL_IMG_LAST 6'd37

// register word indices (byte address = 4 * index)
`define ECFL_IDX_HWCFG 4'h0
`define ECFL_IDX_PMT 4'h1
`define ECFL_IDX_PIPE 4'h2
`define ECFL_IDX_MACCR 4'h3
`define ECFL_IDX_USB0 4'h4
`define ECFL_IDX_USB1 4'h5
`define ECFL_IDX_USB2 4'h6
`define ECFL_IDX_PIN0 4'h7
`define ECFL_IDX_PIN1 4'h8
`define ECFL_IDX_WAKE 4'h9
`define ECFL_IDX_MACL 4'ha
`define ECFL_IDX_MACH 4'hb
`define ECFL_IDX_ATTR 4'hc
`define ECFL_IDX_DESC 4'hd
`define ECFL_IDX_LAST 4'hd

// software writable masks
`define ECFL_MASK_HWCFG 32'h00000f1f
`define ECFL_MASK_PMT 32'h00010000
`define ECFL_MASK_PIPE 32'h0000007f
`define ECFL_MASK_MACCR 32'h00002fc3
`define ECFL_MASK_USB0 32'h000001ff
`define ECFL_MASK_USB1 32'h0000003f
`define ECFL_MASK_USB2 32'h0000ffff
`define ECFL_MASK_PIN 32'h0fff0fff
`define ECFL_MASK_MACL 32'hffffffff
`define ECFL_MASK_MACH 32'h0000ffff
`define ECFL_MASK_ATTR 32'h0000ffff
`define ECFL_MASK_DESC 32'h000000ff

// hardware defaults kept when no valid memory is found
`define ECFL_DEF_REG 32'h00000000
`define ECFL_DEF_VID 16'h1234
`define ECFL_DEF_PID 16'h5678

// field positions
`define ECFL_HW_EMU 0
`define ECFL_HW_SPEEDUP 1
`define ECFL_HW_SUSP_POL 2
`define ECFL_HW_SUSP_SEL 3
`define ECFL_HW_DONE 16
`define ECFL_HW_EE_OK 17
`define ECFL_HW_OTP_OK 18
`define ECFL_F0_ADD 16
`define ECFL_F0_ASD 15
`define ECFL_F0_SUSP_POL 17
`define ECFL_F0_SUSP_SEL 18
`define ECFL_F1_XTAL 16
`define ECFL_F2_SPEEDUP 12
`define ECFL_MAC_ASD 0
`define ECFL_MAC_ADD 1
`define ECFL_USB0_PWR 0
`define ECFL_USB0_RMT 1
`define ECFL_DESC_PWR 6
`define ECFL_DESC_RMT 5

`endif

/* core/ecfl_pkg.sv */
// types of the configuration flag loader
package ecfl_pkg;
  typedef enum logic [2:0] {
    ECFL_EE_SIG,
    ECFL_OTP_SIG,
    ECFL_FETCH,
    ECFL_APPLY,
    ECFL_DONE
  } ecfl_state_t;

  typedef struct packed {
    logic req;
    logic src;
    logic [9:0] addr;
  } ecfl_memreq_t;

  typedef struct packed {
    logic [31:0] hwCfg;
    logic [31:0] pmtCtl;
    logic [31:0] pipeCtl;
    logic [31:0] macCr;
    logic [31:0] usbCfg0;
    logic [31:0] usbCfg1;
    logic [31:0] usbCfg2;
    logic [31:0] pinCfg0;
    logic [31:0] pinCfg1;
    logic [31:0] pinWake;
    logic [31:0] macAddrLow;
    logic [31:0] macAddrHigh;
  } ecfl_cfg_t;
endpackage

/* bench/ecfl_loader_assertions.sv */
// port assertions for the configuration flag loader
`timescale 1ns/1ps
module ecfl_loader_chk
  import ecfl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input ecfl_memreq_t memReq,
  input wire logic memAck,
  input wire logic [7:0] memData,
  input ecfl_cfg_t cfg,
  input wire logic loadDone,
  input wire logic descFromRam
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // signature byte answered at address zero of one memory
  sequence sig_ack(logic s);
    memAck && memReq.src == s && memReq.addr == 10'h000;
  endsequence
  // fetch address set up one cycle, request raised the next
  sequence next_fetch(logic s, logic [9:0] a);
    memReq.src == s && memReq.addr == a ##1 memReq.req;
  endsequence
  a_ack_next: assert property (take |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i[5:2] > 4'hd |=> wb_dat_o == 0)
    else $error("unmapped read not zero");
  a_first_fetch: assert property (
    !$past(rst_n) |-> memReq.req && !memReq.src && memReq.addr == 0)
    else $error("signature not fetched first");
  a_ee_accept: assert property (
    sig_ack(1'b0) ##0 memData == 8'ha5 |=> next_fetch(1'b0, 10'h001))
    else $error("valid eeprom not read");
  a_ee_reject: assert property (
    sig_ack(1'b0) ##0 memData != 8'ha5 |=> next_fetch(1'b1, 10'h000))
    else $error("bad eeprom not skipped");
  a_otp_low: assert property (
    sig_ack(1'b1) ##0 memData == 8'hf3 |=> next_fetch(1'b1, 10'h001))
    else $error("otp low image misplaced");
  a_otp_high: assert property (
    sig_ack(1'b1) ##0 memData == 8'hf7 |=> next_fetch(1'b1, 10'h101))
    else $error("otp high image misplaced");
  a_otp_reject: assert property (
    sig_ack(1'b1) ##0 memData != 8'hf3 && memData != 8'hf7 |=> !memReq.req ##[0:2] loadDone)
    else $error("blank otp still read");
  a_done_hold: assert property (loadDone |=> loadDone) else $error("done dropped");
  a_done_quiet: assert property (loadDone |-> !memReq.req && !memAck)
    else $error("fetch after done");
  a_desc_source: assert property (descFromRam == cfg.hwCfg[0])
    else $error("descriptor source mismatch");
  a_emu_by_write: assert property (
    $rose(descFromRam) |-> $past(wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h0))
    else $error("descriptor source changed without a write");
  a_pmt_reserved: assert property ((cfg.pmtCtl & 32'hfffeffff) == 32'h0)
    else $error("reserved power bits set");
endmodule

bind ecfl_loader ecfl_loader_chk u_chk (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .memReq(memReq),
  .memAck(memAck), .memData(memData), .cfg(cfg), .loadDone(loadDone),
  .descFromRam(descFromRam)
);

/* bench/ecfl_mem_model.sv */
// behavioural eeprom and otp answering the loader's byte requests
`timescale 1ns/1ps
module ecfl_mem_model
  import ecfl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input ecfl_memreq_t memReq,
  output logic memAck,
  output logic [7:0] memData
);
  logic [7:0] eeprom [0:1023];
  logic [7:0] otp [0:1023];
  int lat = 0;
  int waitCount;
  // outside the answer cycle the data toggles, so a loader sampling one cycle late sees the inverted byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      memData <= 8'h5a;
      waitCount <= 0;
    end else if (memReq.req && !memAck && waitCount >= lat) begin
      memAck <= 1'b1;
      waitCount <= 0;
      memData <= memReq.src ? otp[memReq.addr] : eeprom[memReq.addr];
    end else begin
      memAck <= 1'b0;
      memData <= ~memData;
      if (memReq.req && !memAck) begin
        waitCount <= waitCount + 1;
      end
    end
  end
endmodule

/* bench/tb_top.sv */
// self-checking bench for the configuration flag loader
`timescale 1ns/1ps
`include "ecfl_consts.svh"
module tb_top
  import ecfl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  ecfl_memreq_t memReq;
  logic memAck, loadDone, descFromRam, ack;
  logic [7:0] memData;
  ecfl_cfg_t cfg;
  logic [15:0] vendorId, productId;
  int numErrors = 0, numChecks = 0, cycles = 0;

  ecfl_loader u_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .memReq(memReq), .memAck(memAck), .memData(memData), .cfg(cfg), .loadDone(loadDone),
    .descFromRam(descFromRam), .vendorId(vendorId), .productId(productId));
  ecfl_mem_model u_mem (.clk(clk), .rst_n(rst_n), .memReq(memReq), .memAck(memAck),
    .memData(memData));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic testDone();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // a full run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      numErrors = numErrors + 1;
      testDone();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    @(posedge clk);
    // no limit here: only the bench timeout ends a wait for ack
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(q, e);
  endtask

  function automatic logic [7:0] memByte(input logic s, input int a);
    return s ? 8'(a * 13 + 5) : 8'(a * 7 + 3);
  endfunction

  function automatic logic [31:0] imgWord(input logic s, input int a);
    return {memByte(s, a + 3), memByte(s, a + 2), memByte(s, a + 1), memByte(s, a)};
  endfunction

  task automatic boot(input logic [7:0] eeSig, input logic [7:0] otpSig, input int slow);
    int n;
    n = 0;
    u_mem.eeprom[0] = eeSig;
    u_mem.otp[0] = otpSig;
    u_mem.lat = slow;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    while (loadDone !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check(32'(loadDone), 32'h1);
  endtask

  task automatic noMemory();
    boot(`ECFL_OTP_SIG_LOW, `ECFL_EE_SIG, 1);
    check(32'(|cfg), 32'h0);
    check({productId, vendorId}, {`ECFL_DEF_PID, `ECFL_DEF_VID});
    rd(6'h00, 32'h00010000);
    rd(6'h38, 32'h0);
    wr(6'h28, 32'h11223344);
    rd(6'h28, 32'h11223344);
    wr(6'h1c, 32'hffffffff);
    rd(6'h1c, 32'h0fff0fff);
    wr(6'h30, 32'h00000012);
    wr(6'h34, 32'h00000060);
    check(32'(descFromRam), 32'h0);
    wr(6'h00, 32'h00000f01);
    check(32'(descFromRam), 32'h1);
    check(cfg.usbCfg0, 32'h3);
    rd(6'h00, 32'h00010f01);
    $display("no memory test done");
  endtask

  task automatic badOrder();
    boot(8'h00, 8'h00, 0);
    wr(6'h34, 32'h00000060);
    wr(6'h30, 32'h00000012);
    wr(6'h00, 32'h00000001);
    check(cfg.usbCfg0, 32'h0);
    $display("order test done");
  endtask

  task automatic loadCase(input logic [7:0] eeSig, input logic [7:0] otpSig, input logic s,
      input int b, input int slow);
    logic [31:0] f0, f1, f2, h;
    boot(eeSig, otpSig, slow);
    f0 = imgWord(s, b + 6);
    f1 = imgWord(s, b + 10);
    f2 = imgWord(s, b + 14);
    h = {27'h0, f0[19:17], f2[12], 1'b0};
    check(cfg.hwCfg, h);
    check(cfg.pmtCtl, {15'h0, f1[16], 16'h0});
    check(cfg.pipeCtl, {25'h0, f1[6:0]});
    check(cfg.macCr, (f2 & 32'h00002fc0) | {30'h0, f0[16:15]});
    check(cfg.usbCfg0, {25'h0, f0[6:0]});
    check(cfg.usbCfg1, {26'h0, f2[5:0]});
    check(cfg.usbCfg2, imgWord(s, b + 18) & 32'h0000ffff);
    check(cfg.pinCfg0, imgWord(s, b + 22) & 32'h0fff0fff);
    check(cfg.pinCfg1, imgWord(s, b + 26) & 32'h0fff0fff);
    check(cfg.pinWake, imgWord(s, b + 30) & 32'h0fff0fff);
    check(cfg.macAddrLow, imgWord(s, b));
    check(cfg.macAddrHigh, imgWord(s, b + 4) & 32'h0000ffff);
    check({productId, vendorId}, imgWord(s, b + 34));
    rd(6'h00, h | {13'h0, s, !s, 1'b1, 16'h0});
    $display("load test done");
  endtask

  initial begin
    for (int i = 0; i < 1024; i++) begin
      u_mem.eeprom[i] = memByte(1'b0, i);
      u_mem.otp[i] = memByte(1'b1, i);
    end
    @(posedge clk);
    noMemory();
    badOrder();
    loadCase(`ECFL_EE_SIG, `ECFL_OTP_SIG_HIGH, 1'b0, 1, 0);
    loadCase(8'h00, `ECFL_OTP_SIG_LOW, 1'b1, 1, 3);
    loadCase(8'ha4, `ECFL_OTP_SIG_HIGH, 1'b1, 'h101, 2);
    testDone();
  end
endmodule
